// [dcei_pkg.sv]
// Shared constants for the direct control link
package dcei_pkg;
    localparam int unsigned CLK_PERIOD_NS   = 40;
    localparam int unsigned HOLD_MIN_NS     = 500;
    localparam int unsigned PULSE_MIN_NS    = 500;
    localparam int unsigned PULSE_MAX_NS    = 1000;
    localparam int unsigned SETUP_MIN_NS    = 100;
    // Least times round up, longest times round down
    localparam int unsigned PULSE_MIN_CYC   = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned PULSE_MAX_CYC   = PULSE_MAX_NS / CLK_PERIOD_NS;
    localparam int unsigned HOLD_MIN_CYC    = (HOLD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SETUP_MIN_CYC   = (SETUP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned PULSE_CYC       = PULSE_MIN_CYC + 1;
    localparam int unsigned CNT_W           = 6;
    localparam int unsigned BYTE_W          = 8;
    localparam int unsigned REQ_LO          = 2;
    localparam int unsigned REQ_N           = 6;
    localparam int unsigned CODE_LSB        = 26;
    localparam int unsigned MASK_BIT        = 7;
    localparam logic [7:0]  OLD_WORD_LOC    = 8'h18;
    localparam logic [7:0]  NEW_WORD_LOC    = 8'h58;
endpackage

// [dcei_if.sv]
// Interface joining the processor end and the external party end
`timescale 1ns/1ps
interface dcei_if;
    logic [7:0] sig_lines;
    logic       read_pulse;
    logic       hold_line;
    logic [7:0] data_in_bus;
    logic [7:0] sig_in_lines;
    modport cpu (output sig_lines, output read_pulse, input hold_line, input data_in_bus,
                 input sig_in_lines);
    modport ext (input sig_lines, input read_pulse, output hold_line, output data_in_bus,
                 output sig_in_lines);
endinterface // dcei_if

// [dcei_ext.sv]
// External party end: drives hold line and data byte, sends request pulses
`timescale 1ns/1ps
module dcei_ext (
    input  wire logic       mclk_i,
    input  wire logic       rst_i,
    input  wire logic [7:0] data_i,
    input  wire logic       data_load_i,
    input  wire logic [7:2] req_i,
    output logic            busy_o,
    output logic            read_seen_o,
    dcei_if.ext             link
);
    localparam int unsigned CNT_W = dcei_pkg::CNT_W;

    typedef enum logic [1:0] {DX_IDLE, DX_PRE, DX_POST, DX_LOW} dcei_xst_t;
    dcei_xst_t              st_r;
    logic [dcei_pkg::CNT_W-1:0] cnt_r;
    logic [7:0]             byte_r;
    logic [7:0]             pend_byte_r;
    logic                   pend_r;
    logic [7:2]             pulse_r;
    logic [dcei_pkg::CNT_W-1:0] pcnt_r;
    logic                   rd_s1_r;
    logic                   rd_s2_r;
    logic                   rd_d_r;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_s1_r <= 1'b0;
            rd_s2_r <= 1'b0;
            rd_d_r  <= 1'b0;
        end else begin
            rd_s1_r <= link.read_pulse;
            rd_s2_r <= rd_s1_r;
            rd_d_r  <= rd_s2_r;
        end
    end

    // Data change bracketed by hold high, low time kept
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r        <= DX_IDLE;
            cnt_r       <= '0;
            byte_r      <= 8'h00;
            pend_byte_r <= 8'h00;
            pend_r      <= 1'b0;
        end else begin
            if (data_load_i) begin
                pend_byte_r <= data_i;
                pend_r      <= 1'b1;
            end
            unique case (st_r)
                DX_IDLE: if (pend_r) begin
                    st_r  <= DX_PRE;
                    cnt_r <= '0;
                end
                DX_PRE: begin
                    cnt_r <= cnt_r + 1'b1;
                    if (cnt_r == CNT_W'(dcei_pkg::SETUP_MIN_CYC)) begin // RL1
                        byte_r <= pend_byte_r;
                        if (!data_load_i) pend_r <= 1'b0;
                        st_r  <= DX_POST;
                        cnt_r <= '0;
                    end
                end
                DX_POST: begin
                    cnt_r <= cnt_r + 1'b1;
                    if (cnt_r >= CNT_W'(dcei_pkg::HOLD_MIN_CYC)) begin // RL1 RL2
                        st_r  <= DX_LOW;
                        cnt_r <= '0;
                    end
                end
                DX_LOW: begin
                    cnt_r <= cnt_r + 1'b1;
                    if (cnt_r >= CNT_W'(dcei_pkg::HOLD_MIN_CYC)) begin // RL2
                        st_r <= DX_IDLE;
                    end
                end
            endcase
        end
    end

    // Fixed-width request pulses with low gap
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            pulse_r <= '0;
            pcnt_r  <= '0;
        end else if (pcnt_r != '0) begin
            pcnt_r <= pcnt_r - 1'b1;
            if (pcnt_r == CNT_W'(dcei_pkg::PULSE_MIN_CYC + 1)) pulse_r <= '0; // RL12
        end else if (req_i != '0) begin
            pulse_r <= req_i; // RL14
            pcnt_r  <= CNT_W'(2 * dcei_pkg::PULSE_MIN_CYC + 1); // RL12
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) read_seen_o <= 1'b0;
        else       read_seen_o <= rd_s2_r & ~rd_d_r; // RL4
    end

    assign busy_o             = (st_r != DX_IDLE) | pend_r;
    assign link.hold_line     = (st_r == DX_PRE) | (st_r == DX_POST); // RL4
    assign link.data_in_bus   = byte_r;
    assign link.sig_in_lines  = {pulse_r, 2'b00};
endmodule // dcei_ext

// [dcei_cpu.sv]
// Processor end: read handshake, outbound pulses, external interrupt capture
//
// Function
// [RL1] Hold high 100 ns around data change
// [RL2] Hold high and low at least 500 ns
// [RL3] After read pulse, wait hold low, sample
// [RL4] Far side drops hold promptly after read; dcei_ext times hold_line by its own counters and ignores read_seen_o
// [RL5] Hold may change anytime around read pulse
// [RL6] Lines 2-7 map to code bits 26-31
// [RL7] Take interrupt at boundary, mask bit 7 set
// [RL8] Store old word 24, load new 88
// [RL9] Pending until honored, all reported once
// [RL10] Repeats merge into one pending request
// [RL11] Capture edges, stuck high never hangs
// [RL12] Request pulses 500-1000 ns, 500 ns gap
// [RL13] Outbound pulse leading edges skew under 200 ns
// [RL14] No meaning in simultaneous request combinations
// [RL15] Request inputs treated as asynchronous
// [RL16] Two-stage sync; clear pending when stored
`timescale 1ns/1ps
module dcei_cpu #(
    parameter int unsigned PULSE_CYC = dcei_pkg::PULSE_CYC
) (
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    input  wire logic        read_req_i,
    input  wire logic [7:0]  sig_bits_i,
    input  wire logic        insn_end_i,
    input  wire logic        sys_mask_i,
    output logic             read_busy_o,
    output logic             read_done_o,
    output logic [7:0]       read_byte_o,
    output logic             int_take_o,
    output logic [31:0]      int_code_o,
    output logic [7:0]       old_loc_o,
    output logic [7:0]       new_loc_o,
    output logic [5:0]       pending_o,
    dcei_if.cpu              link
);
    localparam int unsigned CNT_W = dcei_pkg::CNT_W;

    // ------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------
    if ((PULSE_CYC < dcei_pkg::PULSE_MIN_CYC) ||
        (PULSE_CYC > dcei_pkg::PULSE_MAX_CYC)) begin : g_bad_width
        $error("pulse width outside allowed range");
    end

    if (PULSE_CYC >= (1 << CNT_W)) begin : g_bad_count
        $error("pulse width does not fit the counter");
    end

    if (dcei_pkg::CODE_LSB + dcei_pkg::REQ_N != 32) begin : g_bad_code
        $error("request lines do not fill the code field");
    end

    typedef enum logic [1:0] {DC_IDLE, DC_PULSE, DC_WAIT} dcei_rst_t;

    // ------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------
    logic       hold_s1_r;
    logic       hold_s2_r;
    logic [5:0] req_s1_r;
    logic [5:0] req_s2_r;
    logic [5:0] req_d_r;
    logic [7:0] data_s1_r;
    logic [7:0] data_s2_r;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            hold_s1_r <= 1'b0;
            hold_s2_r <= 1'b0;
            req_s1_r  <= '0;
            req_s2_r  <= '0;
            req_d_r   <= '0;
            data_s1_r <= 8'h00;
            data_s2_r <= 8'h00;
        end else begin
            hold_s1_r <= link.hold_line; // RL16 RL5
            hold_s2_r <= hold_s1_r;
            req_s1_r  <= link.sig_in_lines[7:dcei_pkg::REQ_LO]; // RL6 RL15 RL16
            req_s2_r  <= req_s1_r;
            req_d_r   <= req_s2_r;
            data_s1_r <= link.data_in_bus;
            data_s2_r <= data_s1_r;
        end
    end

    // ------------------------------------------------------------
    // Read handshake
    // ------------------------------------------------------------
    dcei_rst_t              rst_st_r;
    logic [CNT_W-1:0]       rcnt_r;
    logic                   rpulse_r;
    logic [7:0]             sig_out_r;
    logic                   start;
    logic                   pulse_end;
    logic                   data_ok;

    // Read accepted only when idle
    assign start     = (rst_st_r == DC_IDLE) & read_req_i;
    assign pulse_end = (rst_st_r == DC_PULSE) & (rcnt_r == CNT_W'(1));
    // Hold sampled only after the pulse has ended
    assign data_ok   = (rst_st_r == DC_WAIT) & ~hold_s2_r; // RL3 RL5

    // Handshake state
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rst_st_r <= DC_IDLE;
        end else begin
            unique case (rst_st_r)
                DC_IDLE: if (start) begin
                    rst_st_r <= DC_PULSE;
                end
                DC_PULSE: if (pulse_end) begin
                    rst_st_r <= DC_WAIT;
                end
                DC_WAIT: if (data_ok) begin // RL3
                    rst_st_r <= DC_IDLE;
                end
            endcase
        end
    end

    // Pulse width counter
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rcnt_r <= '0;
        end else if (start) begin
            rcnt_r <= CNT_W'(PULSE_CYC);
        end else if (rst_st_r == DC_PULSE) begin
            rcnt_r <= rcnt_r - 1'b1;
        end
    end

    // Read pulse and timing pulses share one edge
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rpulse_r  <= 1'b0;
            sig_out_r <= 8'h00;
        end else if (start) begin
            rpulse_r  <= 1'b1; // RL13
            sig_out_r <= sig_bits_i; // RL13
        end else if (pulse_end) begin
            rpulse_r  <= 1'b0;
            sig_out_r <= 8'h00;
        end
    end

    // Byte taken when hold seen low
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            read_done_o <= 1'b0;
            read_byte_o <= 8'h00;
        end else begin
            read_done_o <= data_ok; // RL3
            if (data_ok) begin
                read_byte_o <= data_s2_r; // RL3 RL1
            end
        end
    end

    // Busy from accept to sample
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            read_busy_o <= 1'b0;
        end else if (start) begin
            read_busy_o <= 1'b1;
        end else if (data_ok) begin
            read_busy_o <= 1'b0;
        end
    end

    assign link.read_pulse = rpulse_r;
    assign link.sig_lines  = sig_out_r;

    // ------------------------------------------------------------
    // External interrupt capture
    // ------------------------------------------------------------
    logic [5:0] pend_r;
    logic [5:0] rise;
    logic       take;

    // Interruption code from pending lines
    function automatic logic [31:0] code_word(input logic [5:0] lines);
        return 32'(lines) << dcei_pkg::CODE_LSB;
    endfunction

    assign rise = req_s2_r & ~req_d_r; // RL11
    assign take = insn_end_i & sys_mask_i & (pend_r != '0); // RL7

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            pend_r <= '0;
        end else if (take) begin
            pend_r <= rise; // RL9 RL16
        end else begin
            pend_r <= pend_r | rise; // RL10
        end
    end

    // ------------------------------------------------------------
    // Interrupt report
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            int_take_o <= 1'b0;
        end else begin
            int_take_o <= take; // RL7
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            int_code_o <= 32'h0000_0000;
            old_loc_o  <= 8'h00;
            new_loc_o  <= 8'h00;
        end else if (take) begin
            int_code_o <= code_word(pend_r); // RL6 RL9
            old_loc_o  <= dcei_pkg::OLD_WORD_LOC; // RL8
            new_loc_o  <= dcei_pkg::NEW_WORD_LOC; // RL8
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            pending_o <= 6'h00;
        end else begin
            pending_o <= pend_r; // RL9
        end
    end
endmodule // dcei_cpu

// [dcei_checker.sv]
// Interface checks for the direct control link
`timescale 1ns/1ps
module dcei_checker (
    input  wire logic       mclk_i,
    input  wire logic       rst_i,
    input  wire logic [7:0] sig_lines,
    input  wire logic       read_pulse,
    input  wire logic       hold_line,
    input  wire logic [7:0] data_in_bus,
    input  wire logic [7:0] sig_in_lines
);
    // ----
    // Wire checks
    // ----
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    a_hold_high_min: assert property (
        $rose(hold_line) |-> hold_line[*8] ##1 hold_line[*5]) else $error("hold high short");
    a_hold_low_min: assert property (
        $fell(hold_line) |-> !hold_line[*8] ##1 !hold_line[*5]) else $error("hold low short");
    a_data_setup: assert property (
        $changed(data_in_bus) |-> hold_line && $past(hold_line) && $past(hold_line, 2)
        && $past(hold_line, 3)) else $error("data changed without hold");
    a_data_hold: assert property (
        $changed(data_in_bus) |-> hold_line[*3]) else $error("hold dropped after data");
    a_read_width: assert property (
        $rose(read_pulse) |-> read_pulse[*8] ##1 read_pulse[*6] ##1 !read_pulse)
        else $error("read pulse width");
    a_sig_skew: assert property (
        (|(sig_lines & ~$past(sig_lines))) |-> read_pulse && !$past(read_pulse, 4))
        else $error("timing pulse skew");
    a_sig_max_width: assert property (
        (|sig_lines) |-> ##[1:25] sig_lines == 8'h00) else $error("timing pulse too long");
    a_hold_release: assert property (
        $fell(read_pulse) |-> ##[0:30] !hold_line) else $error("hold not released");
    a_req_high_min: assert property (
        $rose(|sig_in_lines) |-> (|sig_in_lines)[*8] ##1 (|sig_in_lines)[*5])
        else $error("request pulse short");
    a_req_high_max: assert property (
        $rose(|sig_in_lines) |-> ##[13:25] !(|sig_in_lines)) else $error("request pulse long");
    a_req_low_min: assert property (
        $fell(|sig_in_lines) |-> (!(|sig_in_lines))[*8] ##1 (!(|sig_in_lines))[*5])
        else $error("request gap short");
endmodule // dcei_checker

// [direct_control_ext_interrupt_tb.sv]
// Self-checking bench for both ends of the direct control link
`timescale 1ns/1ps
module direct_control_ext_interrupt_tb;
    logic        mclk_i = 1'b0, rst_i = 1'b1, read_req_i = 1'b0, data_load_i = 1'b0;
    logic        insn_end_i = 1'b0, sys_mask_i = 1'b0;
    logic        read_busy_o, read_done_o, int_take_o, busy_o, read_seen_o;
    logic [7:0]  sig_bits_i = 8'h00, data_i = 8'h00, last = 8'h00;
    logic [7:0]  read_byte_o, old_loc_o, new_loc_o;
    logic [5:0]  pending_o, req_i = 6'h00, pend = 6'h00;
    logic [31:0] int_code_o, seed = 32'h4DE6;
    logic [31:0] rd_q[$], int_q[$];
    int          failures = 0, n_tests = 0;
    int          n_reads = 0, n_seen = 0;
    dcei_if link_if ();
    dcei_cpu i_dcei_cpu (.mclk_i(mclk_i), .rst_i(rst_i), .read_req_i(read_req_i),
        .sig_bits_i(sig_bits_i), .insn_end_i(insn_end_i), .sys_mask_i(sys_mask_i),
        .read_busy_o(read_busy_o), .read_done_o(read_done_o), .read_byte_o(read_byte_o),
        .int_take_o(int_take_o), .int_code_o(int_code_o), .old_loc_o(old_loc_o),
        .new_loc_o(new_loc_o), .pending_o(pending_o), .link(link_if));
    dcei_ext i_dcei_ext (.mclk_i(mclk_i), .rst_i(rst_i), .data_i(data_i),
        .data_load_i(data_load_i), .req_i(req_i), .busy_o(busy_o),
        .read_seen_o(read_seen_o), .link(link_if));
    dcei_checker i_dcei_checker (.mclk_i(mclk_i), .rst_i(rst_i),
        .sig_lines(link_if.sig_lines), .read_pulse(link_if.read_pulse),
        .hold_line(link_if.hold_line), .data_in_bus(link_if.data_in_bus),
        .sig_in_lines(link_if.sig_in_lines));
    // ----
    // Helpers
    // ----
    always #20 mclk_i = ~mclk_i;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge mclk_i);
        #2;
    endtask
    task automatic wait_idle();
        int k;
        k = 0;
        while ((read_busy_o !== 1'b0 || busy_o !== 1'b0) && k < 300) begin
            step(1);
            k++;
        end
        if (k == 300) begin
            failures++;
            finish_test();
        end
    endtask
    // Read with optional byte change racing it
    task automatic do_read(input logic [7:0] pat, input logic ld);
        seed = lfsr(seed);
        req_i = pat[7:2];
        n_reads++;
        if (ld)
            last = seed[7:0];
        data_i = last;
        data_load_i = ld;
        rd_q.push_back({24'h0, last});
        pend = pend | pat[7:2];
        sig_bits_i = pat;
        read_req_i = 1'b1;
        step(1);
        read_req_i = 1'b0;
        data_load_i = 1'b0;
        req_i = 6'h00;
        wait_idle();
        sig_bits_i = 8'h00;
    endtask
    task automatic take(input logic m);
        check("pending before", {26'h0, pending_o}, {26'h0, pend});
        if (m && pend != 6'h00) begin
            int_q.push_back({pend, 26'h0});
            pend = 6'h00;
        end
        sys_mask_i = m;
        insn_end_i = 1'b1;
        step(1);
        insn_end_i = 1'b0;
        step(2 * dcei_pkg::PULSE_MIN_CYC + 2);
        check("pending after", {26'h0, pending_o}, {26'h0, pend});
    endtask
    // ----
    // Result watcher
    // ----
    always @(negedge mclk_i) begin
        if (read_seen_o === 1'b1) n_seen++;
        if (read_done_o === 1'b1) begin
            if (rd_q.size() == 0) check("read extra", 32'h1, 32'h0);
            else check("read byte", {24'h0, read_byte_o}, rd_q.pop_front());
        end
        if (int_take_o === 1'b1) begin
            if (int_q.size() == 0) check("take extra", 32'h1, 32'h0);
            else check("int code", int_code_o, int_q.pop_front());
            check("old loc", {24'h0, old_loc_o}, 32'h18);
            check("new loc", {24'h0, new_loc_o}, 32'h58);
        end
    end
    // ----
    // Main sequence
    // ----
    initial begin
        step(2);
        rst_i = 1'b0;
        step(1);
        do_read(8'h00, 1'b1);
        do_read(8'h00, 1'b0);
        do_read(8'h00, 1'b1);
        $display("test read done");
        do_read(8'hFF, 1'b0);
        take(1'b0);
        take(1'b1);
        take(1'b1);
        $display("test mask done");
        for (int i = 0; i < 6; i++) begin
            do_read(8'h04 << i, 1'b1);
            do_read(8'h04 << i, 1'b0);
            take(1'b1);
        end
        seed = lfsr(seed);
        do_read(seed[7:0], 1'b1);
        take(1'b1);
        $display("test lines done");
        step(5);
        check("queues empty", rd_q.size() + int_q.size(), 32'h0);
        check("read seen", n_seen, n_reads);
        finish_test();
    end
endmodule // direct_control_ext_interrupt_tb
